// File: output_combiner_pkg.sv
/*
 * constants, field layout and carrier types for the configurable
 * output combiner: eight output pins, one config word per page.
 * assumes a 100 MHz system clock and a command port that delivers
 * page, command code and 32-bit data words.
 */
package output_combiner_pkg;

    // ------------------------------------------------------------
    // pin and channel counts
    // ------------------------------------------------------------
    localparam int          NUM_PINS        = 8;
    localparam int          NUM_CHANNELS    = 16;

    // ------------------------------------------------------------
    // command addressing
    // ------------------------------------------------------------
    localparam logic [7:0]  FIRST_PIN_PAGE  = 8'h15;   // page 21
    localparam logic [7:0]  LAST_PIN_PAGE   = 8'h1c;   // page 28
    localparam logic [7:0]  OUTPUT_PIN_CONFIG_CODE = 8'hf8;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int          MASK_LSB        = 16;
    localparam int          MASK_MSB        = 31;
    localparam int          OFF_DELAY_LSB   = 12;
    localparam int          ON_DELAY_LSB    = 8;
    localparam int          DRIVE_TYPE_POS  = 7;
    localparam int          POLARITY_POS    = 6;
    localparam logic [31:0] ZERO_FIELD_MASK = 32'h0000_0038;  // bits 5:3

    // ------------------------------------------------------------
    // reset value and timing
    // ------------------------------------------------------------
    localparam logic [31:0] CONFIG_RESET    = 32'h0000_0000;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          MS_TICK_NS      = 1000000;
    localparam int          MS_TICK_CYCLES  = MS_TICK_NS / CLK_PERIOD_NS;
    localparam int          DELAY_MS_WIDTH  = 12;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_ALTERNATE = 3'h0,
        SRC_FORCE_ON  = 3'h1,
        SRC_FORCE_OFF = 3'h2,
        SRC_GOOD_AND  = 3'h3,
        SRC_ALARM_OR  = 3'h4
    } source_sel_t;

    typedef enum logic [1:0] {
        ALARM_NONE    = 2'h0,
        ALARM_WARNING = 2'h1,
        ALARM_FAULT   = 2'h2,
        ALARM_EITHER  = 2'h3
    } alarm_kind_t;

    typedef struct packed {
        logic [15:0] good_input_channel_mask;
        logic [3:0]  off_delay;
        logic [3:0]  on_delay;
        logic        drive_type_bit;   // 1 = open drain
        logic        polarity_bit;     // 1 = active high
        logic [2:0]  zero_bits;
        logic [2:0]  source;
    } pin_cfg_t;

    typedef struct packed {
        logic [7:0]  page;
        logic [7:0]  code;
        logic        wr;
        logic        rd;
        logic [31:0] wdata;
    } cmd_req_t;

    // ------------------------------------------------------------
    // hold-off code to milliseconds
    // ------------------------------------------------------------
    function automatic logic [DELAY_MS_WIDTH-1:0] delay_ms(input logic [3:0] code);
        case (code)
            4'h0:    delay_ms = 12'd0;
            4'h1:    delay_ms = 12'd5;
            4'h2:    delay_ms = 12'd10;
            4'h3:    delay_ms = 12'd20;
            4'h4:    delay_ms = 12'd40;
            4'h5:    delay_ms = 12'd60;
            4'h6:    delay_ms = 12'd80;
            4'h7:    delay_ms = 12'd100;
            4'h8:    delay_ms = 12'd200;
            4'h9:    delay_ms = 12'd400;
            4'ha:    delay_ms = 12'd600;
            4'hb:    delay_ms = 12'd800;
            4'hc:    delay_ms = 12'd1000;
            4'hd:    delay_ms = 12'd1500;
            4'he:    delay_ms = 12'd2000;
            default: delay_ms = 12'd4000;
        endcase
    endfunction

endpackage

// File: holdoff_qualifier.sv
/*
 * one pin's hold-off qualifier: the combined input must stay static
 * for the selected assert or deassert delay before the state follows.
 * assumes a one-cycle millisecond tick from the caller's divider.
 */
`timescale 1ns/100ps
module holdoff_qualifier (
    input  wire logic       sys_clk,     // system clock
    input  wire logic       rst_n,       // async reset, active low
    input  wire logic       ms_tick,     // one pulse per millisecond
    input  wire logic       delays_on,   // hold-off applies in this mode
    input  wire logic       raw,         // combined input
    input  wire logic [3:0] on_code,     // assert hold-off code
    input  wire logic [3:0] off_code,    // deassert hold-off code
    output logic            qualified    // delayed state
);
    import output_combiner_pkg::*;

    logic                      prev_raw;
    logic [DELAY_MS_WIDTH-1:0] elapsed;
    logic [DELAY_MS_WIDTH-1:0] target;

    assign target = raw ? delay_ms(on_code) : delay_ms(off_code);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_raw <= 1'b0;
        end else begin
            prev_raw <= raw;
        end
    end

    // count granularity is one tick, so up to 1 ms less may elapse
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            qualified <= 1'b0;
            elapsed   <= '0;
        end else if (!delays_on) begin
            qualified <= raw;
            elapsed   <= '0;
        end else if (raw != prev_raw || raw == qualified) begin
            elapsed   <= '0;
        end else if (elapsed >= target) begin
            qualified <= raw;
            elapsed   <= '0;
        end else if (ms_tick) begin
            elapsed   <= elapsed + 12'd1;
        end
    end

endmodule

// File: configurable_output_combiner.sv
/*
 * eight configurable output pins: per-page config words, source
 * selection, masked AND/OR combination, hold-off, polarity and drive.
 * assumes channel good and alarm inputs arrive asynchronously and the
 * alternate-function levels come from logic on sys_clk.
 */
`timescale 1ns/100ps
module configurable_output_combiner #(
    parameter int MS_CYCLES = output_combiner_pkg::MS_TICK_CYCLES
) (
    input  wire logic                         sys_clk,      // 100 MHz clock
    input  wire logic                         rst_n,        // async reset, active low
    input  wire output_combiner_pkg::cmd_req_t cmd,         // page, code, strobes, data
    output logic [31:0]                       cmd_rdata,    // read data
    output logic                              cmd_rvalid,   // read answered, one cycle
    output logic                              cmd_hit,      // access decoded, one cycle
    input  wire logic [15:0]                  power_good,   // channel good or general input
    input  wire logic [15:0]                  ch_warning,   // channel warning flags
    input  wire logic [15:0]                  ch_fault,     // channel fault flags
    input  wire logic [31:0]                  alarm_kind,   // 2 bits per channel
    input  wire logic [7:0]                   alt_level,    // alternate function level
    input  wire logic [7:0]                   alt_drive,    // alternate function enable
    output logic [7:0]                        pin_out,      // general output pin level
    output logic [7:0]                        pin_oe        // general output pin enable
);
    import output_combiner_pkg::*;

    // ------------------------------------------------------------
    // configuration store
    // ------------------------------------------------------------
    pin_cfg_t    cfg [NUM_PINS];
    logic        page_ok;
    logic [2:0]  pin_idx;
    logic [7:0]  page_off;

    assign page_off = cmd.page - FIRST_PIN_PAGE;
    assign pin_idx  = page_off[2:0];
    assign page_ok  = (cmd.page >= FIRST_PIN_PAGE) && (cmd.page <= LAST_PIN_PAGE)
                    && (cmd.code == OUTPUT_PIN_CONFIG_CODE);

    // rewrites take effect at once; quiet supplies are the host's job
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                cfg[i] <= pin_cfg_t'(CONFIG_RESET);
            end
        end else if (cmd.wr && page_ok) begin
            cfg[pin_idx] <= pin_cfg_t'(cmd.wdata & ~ZERO_FIELD_MASK);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_rdata  <= 32'h0000_0000;
            cmd_rvalid <= 1'b0;
            cmd_hit    <= 1'b0;
        end else begin
            cmd_rvalid <= cmd.rd;
            cmd_hit    <= (cmd.rd || cmd.wr) && page_ok;
            if (cmd.rd && page_ok) begin
                cmd_rdata <= 32'(cfg[pin_idx]) & ~ZERO_FIELD_MASK;
            end else if (cmd.rd) begin
                cmd_rdata <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [47:0] sync_meta;
    logic [47:0] sync_q;
    logic [15:0] good_s;
    logic [15:0] warn_s;
    logic [15:0] fault_s;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_meta <= '0;
            sync_q    <= '0;
        end else begin
            sync_meta <= {power_good, ch_warning, ch_fault};
            sync_q    <= sync_meta;
        end
    end

    assign {good_s, warn_s, fault_s} = sync_q;

    // ------------------------------------------------------------
    // channel alarms by kind
    // ------------------------------------------------------------
    logic [15:0] ch_alarm;

    always_comb begin
        for (int c = 0; c < NUM_CHANNELS; c++) begin
            case (alarm_kind_t'(alarm_kind[2*c +: 2]))
                ALARM_WARNING: ch_alarm[c] = warn_s[c];
                ALARM_FAULT:   ch_alarm[c] = fault_s[c];
                ALARM_EITHER:  ch_alarm[c] = warn_s[c] | fault_s[c];
                default:       ch_alarm[c] = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // millisecond tick divider
    // ------------------------------------------------------------
    logic [31:0] div_cnt;
    logic        ms_tick;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 32'h0000_0000;
            ms_tick <= 1'b0;
        end else if (div_cnt >= 32'(MS_CYCLES - 1)) begin
            div_cnt <= 32'h0000_0000;
            ms_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 32'h0000_0001;
            ms_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // per-pin combination, hold-off and pin drive
    // ------------------------------------------------------------
    logic [7:0] raw_comb;
    logic [7:0] delays_on;
    logic [7:0] qualified;

    always_comb begin
        for (int p = 0; p < NUM_PINS; p++) begin
            delays_on[p] = 1'b0;
            case (source_sel_t'(cfg[p].source))
                SRC_GOOD_AND: begin
                    // empty mask reads as all good
                    raw_comb[p]  = &(good_s | ~cfg[p].good_input_channel_mask);
                    delays_on[p] = 1'b1;
                end
                SRC_ALARM_OR: begin
                    raw_comb[p]  = |(ch_alarm & cfg[p].good_input_channel_mask);
                    delays_on[p] = 1'b1;
                end
                SRC_FORCE_ON: raw_comb[p] = 1'b1;
                default:      raw_comb[p] = 1'b0;
            endcase
        end
    end

    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
        holdoff_qualifier u_qual (
            .sys_clk   (sys_clk),
            .rst_n     (rst_n),
            .ms_tick   (ms_tick),
            .delays_on (delays_on[g]),
            .raw       (raw_comb[g]),
            .on_code   (cfg[g].on_delay),
            .off_code  (cfg[g].off_delay),
            .qualified (qualified[g])
        );
    end

    logic [7:0] level;

    always_comb begin
        for (int p = 0; p < NUM_PINS; p++) begin
            level[p] = cfg[p].polarity_bit ? qualified[p] : ~qualified[p];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= 8'h00;
            pin_oe  <= 8'h00;
        end else begin
            for (int p = 0; p < NUM_PINS; p++) begin
                if (cfg[p].source == SRC_ALTERNATE) begin
                    // pins 5 and 6 have no alternate function
                    pin_out[p] <= alt_level[p];
                    pin_oe[p]  <= (p == 5 || p == 6) ? 1'b0 : alt_drive[p];
                end else if (cfg[p].drive_type_bit) begin
                    pin_out[p] <= 1'b0;
                    pin_oe[p]  <= ~level[p];
                end else begin
                    pin_out[p] <= level[p];
                    pin_oe[p]  <= 1'b1;
                end
            end
        end
    end

endmodule

// File: pin_side_model.sv
/* far side of the eight output pins: a pull-up on every line.
   assumes pin_oe high means the block drives the line. */
`timescale 1ns/100ps
module pin_side_model (
    input  wire logic [7:0] pin_out,   // driven level
    input  wire logic [7:0] pin_oe,    // drive enable
    output logic      [7:0] pin_wire   // resolved line level
);
    // a released line floats up, so open drain gets its high level here
    always_comb begin
        for (int i = 0; i < 8; i++) pin_wire[i] = pin_oe[i] ? pin_out[i] : 1'b1;
    end
endmodule

// File: output_combiner_asserts.sv
/* port checker for the output combiner.
   assumes it is bound onto the top module, one clock domain. */
`timescale 1ns/100ps
module output_combiner_asserts #(
    parameter int MS_CYCLES = 10
) (
    input wire logic                          sys_clk,    // clock
    input wire logic                          rst_n,      // reset, active low
    input wire output_combiner_pkg::cmd_req_t cmd,        // request
    input wire logic [31:0]                   cmd_rdata,  // read data
    input wire logic                          cmd_rvalid, // read answer
    input wire logic                          cmd_hit,    // decode hit
    input wire logic [7:0]                    pin_out,    // pin level
    input wire logic [7:0]                    pin_oe      // pin enable
);
    import output_combiner_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] cfg [8];
    logic [31:0] sel_cfg;
    logic [31:0] cfg0;
    logic [7:0]  idx;
    logic        mapped;
    assign idx = cmd.page - FIRST_PIN_PAGE;
    assign mapped = (cmd.wr || cmd.rd) && cmd.code == OUTPUT_PIN_CONFIG_CODE
                    && cmd.page >= FIRST_PIN_PAGE && cmd.page <= LAST_PIN_PAGE;
    assign sel_cfg = cfg[idx[2:0]];
    assign cfg0 = cfg[0];
    // shadow of the config words, kept from the writes seen at the port
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) cfg[i] <= '0;
        end else if (mapped && cmd.wr) begin
            cfg[idx[2:0]] <= cmd.wdata;
        end
    end
    property p_rd_answer; cmd.rd |=> cmd_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_hit; mapped |=> cmd_hit; endproperty
    a_hit: assert property (p_hit) else $error("pin page not decoded");
    property p_no_hit; !mapped |=> !cmd_hit; endproperty
    a_no_hit: assert property (p_no_hit) else $error("stray decode hit");
    property p_zero_bits; cmd_rvalid |-> cmd_rdata[5:3] == 3'h0; endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("bits 5:3 not zero");
    property p_unmapped; cmd.rd && !mapped |=> cmd_rdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_readback;
        cmd.rd && !cmd.wr && mapped |=> cmd_rdata == ($past(sel_cfg) & ~ZERO_FIELD_MASK);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");
    property p_force_level;
        ((cfg0[2:0] == 3'h1 || cfg0[2:0] == 3'h2) && !cfg0[7] && $stable(cfg0)) [*3]
        |-> pin_out[0] == (cfg0[6] == cfg0[0]);
    endproperty
    a_force_level: assert property (p_force_level) else $error("forced level wrong");
    property p_open_drain; (cfg0[7] && cfg0[2:0] != 3'h0) [*3] |-> !pin_out[0]; endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drove high");
    property p_push_pull; (!cfg0[7] && cfg0[2:0] != 3'h0) [*3] |-> pin_oe[0]; endproperty
    a_push_pull: assert property (p_push_pull) else $error("push-pull not driving");
    property p_alt_hiz; (cfg[5][2:0] == 3'h0) [*3] |-> !pin_oe[5]; endproperty
    a_alt_hiz: assert property (p_alt_hiz) else $error("alternate pin not released");
endmodule
bind configurable_output_combiner output_combiner_asserts #(.MS_CYCLES(MS_CYCLES))
    output_combiner_asserts_inst (.sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd),
    .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .cmd_hit(cmd_hit),
    .pin_out(pin_out), .pin_oe(pin_oe));

// File: configurable_output_combiner_tb.sv
/* self-checking bench for the output combiner.
   assumes MS_CYCLES of 10, so a hold-off millisecond is 10 cycles. */
`timescale 1ns/100ps
module configurable_output_combiner_tb;
    import output_combiner_pkg::*;
    localparam int MS = 10;
    logic        sys_clk = 0;
    logic        rst_n = 0;
    cmd_req_t    cmd = '0;
    logic [31:0] cmd_rdata;
    logic        cmd_rvalid;
    logic        cmd_hit;
    logic [15:0] power_good = '0;
    logic [15:0] ch_warning = '0;
    logic [15:0] ch_fault = '0;
    logic [31:0] alarm_kind = '0;
    logic [7:0]  alt_level = '0;
    logic [7:0]  alt_drive = '0;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic [7:0]  pin_wire;
    logic [32:0] expq [$];
    logic [31:0] d;
    logic [31:0] m;
    logic [2:0]  sel;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    configurable_output_combiner #(.MS_CYCLES(MS)) configurable_output_combiner_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd), .cmd_rdata(cmd_rdata),
        .cmd_rvalid(cmd_rvalid), .cmd_hit(cmd_hit), .power_good(power_good),
        .ch_warning(ch_warning), .ch_fault(ch_fault), .alarm_kind(alarm_kind),
        .alt_level(alt_level), .alt_drive(alt_drive), .pin_out(pin_out), .pin_oe(pin_oe));
    pin_side_model pin_side_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .pin_wire(pin_wire));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic access(input logic w, input logic [7:0] pg, input logic [7:0] cd,
                          input logic [31:0] dat);
        @(negedge sys_clk);
        cmd = '{page: pg, code: cd, wr: w, rd: !w, wdata: dat};
        @(negedge sys_clk);
        cmd = '0;
    endtask
    // expected hit flag and data queued before the read goes out
    task automatic rd(input logic [7:0] pg, input logic [7:0] cd, input logic [31:0] exp);
        expq.push_back({cd == OUTPUT_PIN_CONFIG_CODE && pg >= FIRST_PIN_PAGE
                        && pg <= LAST_PIN_PAGE, exp});
        access(1'b0, pg, cd, 32'h0);
    endtask
    task automatic pin_chk(input int p, input logic lvl, input logic od);
        chk({pin_wire[p], pin_oe[p]}, {lvl, od ? !lvl : 1'b1});
    endtask
    function automatic logic [15:0] alarms();
        for (int c = 0; c < 16; c++) begin
            alarms[c] = (alarm_kind[2*c+1] & ch_fault[c]) | (alarm_kind[2*c] & ch_warning[c]);
        end
    endfunction
    always @(negedge sys_clk) begin
        if (cmd_rvalid === 1'b1) begin
            if (expq.size() == 0) chk(64'h1, 64'h0);
            else chk({cmd_hit, cmd_rdata}, expq.pop_front());
        end
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(32'h6f46));
        repeat (16) @(negedge sys_clk);
        rst_n = 1;
        for (int p = 0; p < 8; p++) rd(FIRST_PIN_PAGE + 8'(p), OUTPUT_PIN_CONFIG_CODE, CONFIG_RESET);
        for (int p = 0; p < 8; p++) begin
            d = $urandom();
            access(1'b1, FIRST_PIN_PAGE + 8'(p), OUTPUT_PIN_CONFIG_CODE, d);
            rd(FIRST_PIN_PAGE + 8'(p), OUTPUT_PIN_CONFIG_CODE, d & ~ZERO_FIELD_MASK);
        end
        rd(8'h14, OUTPUT_PIN_CONFIG_CODE, 32'h0);
        access(1'b1, 8'h1d, OUTPUT_PIN_CONFIG_CODE, 32'hffff_ffff);
        rd(8'h1d, OUTPUT_PIN_CONFIG_CODE, 32'h0);
        rd(LAST_PIN_PAGE, OUTPUT_PIN_CONFIG_CODE, d & ~ZERO_FIELD_MASK);
        rd(LAST_PIN_PAGE, 8'hf0, 32'h0);
        // forced modes with random hold-off codes, which must not delay them;
        // first pass push-pull, second pass open drain with spare selects too
        for (int i = 0; i < 16; i++) begin
            m = $urandom();
            sel = m[2] ? ((m[3] && i >= 8) ? 3'h5 + 3'(m[5:4] % 2'h3) : 3'h2) : 3'h1;
            access(1'b1, FIRST_PIN_PAGE + 8'(i % 8), OUTPUT_PIN_CONFIG_CODE,
                   {16'h0, m[31:24], i[3], m[1], 3'b0, sel});
            repeat (6) @(negedge sys_clk);
            pin_chk(i % 8, m[1] ^ m[2], i[3]);
        end
        for (int p = 0; p < 8; p++) access(1'b1, FIRST_PIN_PAGE + 8'(p), OUTPUT_PIN_CONFIG_CODE, 0);
        alt_level = 8'($urandom());
        alt_drive = 8'($urandom());
        repeat (4) @(negedge sys_clk);
        chk({pin_oe, pin_out & 8'h9f}, {alt_drive & 8'h9f, alt_level & 8'h9f});
        // inputs settle before the config word changes, never the reverse
        for (int i = 0; i < 24; i++) begin
            m = (i == 0) ? 32'h0 : $urandom() & $urandom();
            power_good = 16'($urandom() | $urandom());
            ch_warning = 16'($urandom());
            ch_fault = 16'($urandom());
            alarm_kind = $urandom();
            access(1'b1, FIRST_PIN_PAGE + 8'h3, OUTPUT_PIN_CONFIG_CODE,
                   {m[15:0], 8'h00, 8'h40 | (i[0] ? 8'h04 : 8'h03)});
            repeat (8) @(negedge sys_clk);
            pin_chk(3, i[0] ? |(m[15:0] & alarms()) : &(power_good | ~m[15:0]), 1'b0);
        end
        power_good = 0;
        access(1'b1, FIRST_PIN_PAGE + 8'h2, OUTPUT_PIN_CONFIG_CODE, 32'h0001_2143);
        repeat (15*MS) @(negedge sys_clk);
        pin_chk(2, 1'b0, 1'b0);
        repeat (2) begin
            power_good[0] = 1;
            repeat (3*MS) @(negedge sys_clk);
            power_good[0] = 0;
            repeat (5) @(negedge sys_clk);
        end
        pin_chk(2, 1'b0, 1'b0);
        power_good[0] = 1;
        repeat (4*MS + 5) @(negedge sys_clk);
        pin_chk(2, 1'b0, 1'b0);
        repeat (3*MS) @(negedge sys_clk);
        pin_chk(2, 1'b1, 1'b0);
        power_good[0] = 0;
        repeat (9*MS) @(negedge sys_clk);
        pin_chk(2, 1'b1, 1'b0);
        repeat (3*MS) @(negedge sys_clk);
        pin_chk(2, 1'b0, 1'b0);
        chk(64'(expq.size()), 64'h0);
        complete_run();
    end
endmodule
